// *** pkg/addr_decode_pkg.sv ***
// Constants and types for the register window and memory map decoder
`default_nettype none
package addr_decode_pkg;
  localparam int         ADDR_W          = 16;
  localparam int         WSEL_W          = 8;
  // Window select codes (top bit ignored)
  localparam logic [6:0] WIN128_BASE     = 7'h10;
  localparam logic [6:0] WIN128_LAST     = 7'h17;
  localparam logic [6:0] WIN64_BASE      = 7'h20;
  localparam logic [6:0] WIN64_LAST      = 7'h2F;
  localparam logic [6:0] WIN32_BASE      = 7'h40;
  localparam logic [6:0] WIN32_LAST      = 7'h5F;
  // Lower register file windows
  localparam logic [15:0] WIN128_LO      = 16'h0080;
  localparam logic [15:0] WIN64_LO       = 16'h00C0;
  localparam logic [15:0] WIN32_LO       = 16'h00E0;
  localparam logic [15:0] LRF_HI         = 16'h00FF;
  // Memory map boundaries
  localparam logic [15:0] SFR_HI         = 16'h0017;
  localparam logic [15:0] RAM_LO         = 16'h0018;
  localparam logic [15:0] RAM_HI         = 16'h03FF;
  localparam logic [15:0] EXT_LO_LO      = 16'h0400;
  localparam logic [15:0] EXT_LO_HI      = 16'h1FFD;
  localparam logic [15:0] PORT3_ADDR     = 16'h1FFE;
  localparam logic [15:0] PORT4_ADDR     = 16'h1FFF;
  localparam logic [15:0] CFG_LO         = 16'h2000;
  localparam logic [15:0] PROG_LO        = 16'h2080;
  localparam logic [15:0] PROG_HI        = 16'h9FFF;
  localparam logic [15:0] EXT_HI_LO      = 16'hA000;

  typedef enum logic [2:0] {
    REGION_SFR,
    REGION_RAM,
    REGION_PORT,
    REGION_INTERNAL,
    REGION_EXTERNAL
  } region_type;

  typedef struct packed {
    logic [15:0] addr;
    logic        fetch;
    logic        valid;
  } access_type;

  typedef struct packed {
    region_type  region;
    logic [15:0] phys_addr;
    logic        remapped;
    logic        port4;
    logic        valid;
  } decode_type;
endpackage : addr_decode_pkg
`default_nettype wire

// *** rtl/register_window_address_decode.sv ***
// Register window remap and memory map region decoder
// Functional notes
// - Select 10H-17H maps 128-byte block to 80H-FFH
// - Select 20H-2FH maps 64-byte block to C0H-FFH
// - Select 40H-5FH maps 32-byte block to E0H-FFH
// - Windows reach all register RAM to 03FFH
// - Fetches below 0400H go external
// - 2000H-9FFFH internal or external by select
// - 0000H-0017H SFRs, 0018H-03FFH register RAM
// - Other ranges external; 1FFEH/1FFFH are ports
// - Select high: 2000H-9FFFH on chip, low off
`default_nettype none
module register_window_address_decode
  import addr_decode_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire access_type        access,
  input  wire logic [WSEL_W-1:0] window_select_value,
  input  wire logic              external_access_select,
  output var  decode_type        decode
);

  // ********************************************************
  // Pin synchroniser for the external access select
  // ********************************************************
  // Resets low, so program space stays off chip until the pin is seen
  logic ext_sel_meta_reg;
  logic ext_sel_sync_reg;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_sel_meta_reg <= 1'h0;
      ext_sel_sync_reg <= 1'h0;
    end
    else
    begin
      ext_sel_meta_reg <= external_access_select;
      ext_sel_sync_reg <= ext_sel_meta_reg;
    end
  end

  // ********************************************************
  // Access fields
  // ********************************************************
  wire logic [6:0]  wsel     = window_select_value[6:0];
  wire logic [15:0] a        = access.addr;
  wire logic        fetch    = access.fetch;
  wire logic        valid_in = access.valid;

  // ********************************************************
  // Window remap
  // ********************************************************
  wire logic        hit128;
  wire logic        hit64;
  wire logic        hit32;
  wire logic [15:0] map128;
  wire logic [15:0] map64;
  wire logic [15:0] map32;

  // One slice per window size; the code ranges are disjoint, so one hits at most
  window_remap
  #(
    .SEL_BASE (WIN128_BASE),
    .SEL_LAST (WIN128_LAST),
    .WIN_LO   (WIN128_LO)
  )
  win128_i
  (
    .wsel (wsel),
    .addr (a),
    .hit  (hit128),
    .phys (map128)
  );

  window_remap
  #(
    .SEL_BASE (WIN64_BASE),
    .SEL_LAST (WIN64_LAST),
    .WIN_LO   (WIN64_LO)
  )
  win64_i
  (
    .wsel (wsel),
    .addr (a),
    .hit  (hit64),
    .phys (map64)
  );

  window_remap
  #(
    .SEL_BASE (WIN32_BASE),
    .SEL_LAST (WIN32_LAST),
    .WIN_LO   (WIN32_LO)
  )
  win32_i
  (
    .wsel (wsel),
    .addr (a),
    .hit  (hit32),
    .phys (map32)
  );

  // Data accesses only; fetches here are forced off chip anyway
  wire logic        remap = !fetch && (hit128 || hit64 || hit32);
  wire logic [15:0] phys  = !remap ? a :
                            hit128 ? map128 : (hit64 ? map64 : map32);

  // ********************************************************
  // Region decode
  // ********************************************************
  wire logic  low_fetch   = fetch && (a <= RAM_HI);
  wire logic  is_sfr      = (phys <= SFR_HI);
  wire logic  is_ram      = (phys >= RAM_LO) && (phys <= RAM_HI);
  // Plain external ranges, named so the priority below reads as the map
  wire logic  is_ext_low  = (a >= EXT_LO_LO) && (a <= EXT_LO_HI);
  wire logic  is_port     = (a == PORT3_ADDR) || (a == PORT4_ADDR);
  // Vector and configuration bytes follow the program memory select
  wire logic  is_prog     = (a >= CFG_LO) && (a <= PROG_HI);
  wire logic  is_ext_high = (a >= EXT_HI_LO);
  wire logic  on_chip     = is_prog && ext_sel_sync_reg;
  region_type region_next;

  always_comb
  begin
    region_next = REGION_EXTERNAL;
    if (low_fetch)
      region_next = REGION_EXTERNAL;
    else if (is_sfr)
      region_next = REGION_SFR;
    else if (is_ram)
      region_next = REGION_RAM;
    else if (is_port)
      region_next = REGION_PORT;
    else if (is_ext_low || is_ext_high)
      region_next = REGION_EXTERNAL;
    else if (on_chip)
      region_next = REGION_INTERNAL;
  end

  // ********************************************************
  // Registered result
  // ********************************************************
  decode_type decode_reg;
  decode_type decode_next;

  // A fetch keeps its own address even inside a window
  always_comb
  begin
    decode_next           = '0;
    decode_next.region    = region_next;
    decode_next.phys_addr = low_fetch ? a : phys;
    decode_next.remapped  = remap;
    decode_next.port4     = (a == PORT4_ADDR);
    decode_next.valid     = valid_in;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      decode_reg.region    <= REGION_EXTERNAL;
      decode_reg.phys_addr <= 16'h0000;
      decode_reg.remapped  <= 1'h0;
      decode_reg.port4     <= 1'h0;
      decode_reg.valid     <= 1'h0;
    end
    else
      decode_reg <= decode_next;
  end

  // ********************************************************
  // Output
  // ********************************************************
  assign decode = decode_reg;

endmodule : register_window_address_decode

// ********************************************************
// One window size: code range test and block address forming
// ********************************************************
module window_remap
  import addr_decode_pkg::*;
#(
  parameter logic [6:0]  SEL_BASE = WIN128_BASE,
  parameter logic [6:0]  SEL_LAST = WIN128_LAST,
  parameter logic [15:0] WIN_LO   = WIN128_LO
)
(
  input  wire logic [6:0]  wsel,
  input  wire logic [15:0] addr,
  output wire logic        hit,
  output wire logic [15:0] phys
);

  // ********************************************************
  // Sizes
  // ********************************************************
  // Offset bits follow the window size, index bits fill up to the RAM size
  localparam int RAM_AW = $clog2(int'(RAM_HI) + 1);
  localparam int OFS_W  = $clog2(int'(LRF_HI) + 1 - int'(WIN_LO));
  localparam int IDX_W  = RAM_AW - OFS_W;

  // ********************************************************
  // Window code range
  // ********************************************************
  wire logic code_hit = (wsel >= SEL_BASE) && (wsel <= SEL_LAST);
  wire logic addr_hit = (addr >= WIN_LO) && (addr <= LRF_HI);
  assign hit = code_hit && addr_hit;

  // ********************************************************
  // Block address
  // ********************************************************
  // Low IDX_W select bits are the block index, so blocks above 0200H are reached
  assign phys = {{(ADDR_W - RAM_AW){1'h0}}, wsel[IDX_W-1:0], addr[OFS_W-1:0]};

endmodule : window_remap
`default_nettype wire

// *** test/cpu_access_model.sv ***
// Core side model issuing random accesses
`default_nettype none
module cpu_access_model
  import addr_decode_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  output var  access_type        access,
  output var  logic [WSEL_W-1:0] window_select_value,
  output var  logic              external_access_select
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 8675;
  initial
  begin
    // No write data is carried, so no reserved SFR bit is ever set
    access = '0;
    window_select_value = '0;
    external_access_select = 1'b0;
    forever
    begin
      @(posedge clock);
      #1;
      access.addr = $random(seed);
      // Fold a quarter of the traffic low; the high external range stays reachable
      if (access.addr[15:14] == 2'h3) access.addr[15:10] = '0;
      if (access.addr[14:12] == 3'h7) access.addr = {15'h0FFF, access.addr[0]};
      // Reserved bytes, the one after the config byte too, are never accessed
      if ((access.addr >= 16'h2014 && access.addr <= 16'h2017) ||
          (access.addr >= 16'h2019 && access.addr <= 16'h201F) ||
          (access.addr >= 16'h205E && access.addr <= 16'h207F))
        access.addr[15:12] = 4'h3;
      access.fetch = $random(seed);
      access.valid = rstn;
      window_select_value = $random(seed);
      if ($random(seed) % 16 == 0) external_access_select = ~external_access_select;
    end
  end
endmodule : cpu_access_model
`default_nettype wire

// *** test/register_window_address_decode_properties.sv ***
// Checker for the register window and memory map decoder
`default_nettype none
module decode_checker
  import addr_decode_pkg::*;
(
  input wire logic              clock,
  input wire logic              rstn,
  input wire access_type        access,
  input wire logic [WSEL_W-1:0] window_select_value,
  input wire logic              external_access_select,
  input wire decode_type        decode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic [6:0]  w    = window_select_value[6:0];
  wire logic        lo   = !access.fetch && access.addr[15:8] == 8'h00;
  wire logic        m128 = lo && w[6:3] == 4'h2 && access.addr[7];
  wire logic        m64  = lo && w[6:4] == 3'h2 && access.addr[7:6] == 2'h3;
  wire logic        m32  = lo && w[6:5] == 2'h2 && access.addr[7:5] == 3'h7;
  wire logic [15:0] t128 = {6'h00, w[2:0], access.addr[6:0]};
  wire logic [15:0] t64  = {6'h00, w[3:0], access.addr[5:0]};
  wire logic [15:0] t32  = {6'h00, w[4:0], access.addr[4:0]};
  sequence prog_hit; access.addr >= PROG_LO && access.addr <= PROG_HI; endsequence
  sequence sel_held; external_access_select [*3]; endsequence
  sequence sel_low; (!external_access_select) [*3]; endsequence
  chk_win128_map: assert property (m128 |=> decode.remapped && decode.phys_addr == $past(t128))
    else $error("128 byte window wrong");
  chk_win64_map: assert property (m64 |=> decode.remapped && decode.phys_addr == $past(t64))
    else $error("64 byte window wrong");
  chk_win32_map: assert property (m32 |=> decode.remapped && decode.phys_addr == $past(t32))
    else $error("32 byte window wrong");
  chk_no_remap: assert property (lo && !(m128 | m64 | m32) |=> !decode.remapped)
    else $error("remap without window code");
  chk_fetch_low: assert property (access.fetch && access.addr <= RAM_HI |=> decode.region == REGION_EXTERNAL)
    else $error("low fetch not external");
  chk_ram_region: assert property (lo && access.addr >= RAM_LO && !(m128 | m64 | m32) |=> decode.region == REGION_RAM)
    else $error("register ram region wrong");
  chk_port_region: assert property (access.addr >= PORT3_ADDR && access.addr <= PORT4_ADDR |=> decode.region == REGION_PORT)
    else $error("port region wrong");
  chk_prog_internal: assert property (sel_held ##0 prog_hit |=> decode.region == REGION_INTERNAL)
    else $error("program memory not internal");
  chk_prog_external: assert property (sel_low ##0 prog_hit |=> decode.region == REGION_EXTERNAL)
    else $error("program memory not external");
  chk_high_external: assert property (access.addr >= EXT_HI_LO |=> decode.region == REGION_EXTERNAL)
    else $error("high range not external");
endmodule : decode_checker
bind register_window_address_decode decode_checker checker_i (.clock(clock), .rstn(rstn), .access(access),
  .window_select_value(window_select_value), .external_access_select(external_access_select), .decode(decode));
`default_nettype wire

// *** test/tb_top.sv ***
// Random accesses compared with a reference decoder
`default_nettype none
module tb_top
  import addr_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic       external_access_select;
  logic [7:0] window_select_value;
  logic [3:0] sel_hist = '0;
  logic       chk = 1'b0;
  access_type access;
  decode_type decode;
  decode_type expd;
  int         n_errors = 0;
  int         samples_checked = 0;
  function automatic decode_type ref_decode(access_type a, logic [6:0] w, logic sel_on);
    decode_type d;
    logic       lo;
    logic [2:0] m;
    lo = !a.fetch && a.addr[15:8] == 8'h00;
    m = {lo && w[6:3] == 4'h2 && a.addr[7], lo && w[6:4] == 3'h2 && a.addr[7:6] == 2'h3,
         lo && w[6:5] == 2'h2 && a.addr[7:5] == 3'h7};
    d = '0;
    d.valid = a.valid;
    d.remapped = |m;
    d.phys_addr = m[2] ? {6'h00, w[2:0], a.addr[6:0]} : m[1] ? {6'h00, w[3:0], a.addr[5:0]} :
                  m[0] ? {6'h00, w[4:0], a.addr[4:0]} : a.addr;
    d.port4 = d.phys_addr == PORT4_ADDR;
    if (a.fetch && a.addr <= RAM_HI) d.region = REGION_EXTERNAL;
    else if (d.phys_addr <= SFR_HI) d.region = REGION_SFR;
    else if (d.phys_addr <= RAM_HI) d.region = REGION_RAM;
    else if (d.phys_addr >= PORT3_ADDR && d.phys_addr < CFG_LO) d.region = REGION_PORT;
    else if (d.phys_addr >= CFG_LO && d.phys_addr <= PROG_HI && sel_on) d.region = REGION_INTERNAL;
    else d.region = REGION_EXTERNAL;
    return d;
  endfunction : ref_decode
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  cpu_access_model core (.clock(clock), .rstn(rstn), .access(access), .window_select_value(window_select_value),
    .external_access_select(external_access_select));
  register_window_address_decode dut (.clock(clock), .rstn(rstn), .access(access),
    .window_select_value(window_select_value), .external_access_select(external_access_select), .decode(decode));
  initial forever #25 clock = ~clock;
  // Settled results are read mid-cycle; skip cycles while the pin sync catches up
  always @(negedge clock)
  begin
    if (chk && decode !== expd)
    begin
      n_errors++;
      $display("unexpected %0t decode %h want %h", $time, decode, expd);
    end
    samples_checked += chk;
    sel_hist = {sel_hist[2:0], external_access_select};
    expd = ref_decode(access, window_select_value[6:0], sel_hist[0]);
    chk = rstn && (sel_hist == 4'h0 || sel_hist == 4'hF);
  end
  initial
  begin
    repeat (3) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (4000) @(posedge clock);
    end_of_test();
  end
  initial
  begin
    #(50 * 5000);
    n_errors++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
